// File: verilog/flash_erase_pkg.sv
`default_nettype none
package flash_erase_pkg;
  // ==========================================================
  // command words and addresses
  localparam int          ADDR_W        = 21;
  localparam int          DATA_W        = 16;
  localparam logic [20:0] UNLOCK_ADDR_1 = 21'h000555;
  localparam logic [20:0] UNLOCK_ADDR_2 = 21'h0002AA;
  localparam logic [20:0] CHIP_ERASE_ADDR = 21'h000555;
  localparam logic [7:0]  UNLOCK_DATA_1 = 8'hAA;
  localparam logic [7:0]  UNLOCK_DATA_2 = 8'h55;
  localparam logic [7:0]  ERASE_SETUP   = 8'h80;
  localparam logic [7:0]  CHIP_ERASE_CMD   = 8'h10;
  localparam logic [7:0]  SECTOR_ERASE_CMD = 8'h30;
  localparam int          TOGGLE_BIT    = 6;
  localparam int          WRITE_COUNT   = 6;
  // ==========================================================
  // timing
  localparam int CLK_NS          = 40;
  localparam int WP_NS           = 50;
  localparam int WPH_NS          = 35;
  localparam int AH_NS           = 90;
  localparam int OE_NS           = 40;
  localparam int OEHP_NS         = 50;
  localparam int WP_CYC   = (WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WPH_CYC  = (WPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int AH_CYC   = (AH_NS + CLK_NS - 1) / CLK_NS;
  localparam int OE_CYC   = (OE_NS + CLK_NS - 1) / CLK_NS + 3;
  localparam int OEHP_CYC = (OEHP_NS + CLK_NS - 1) / CLK_NS;
  // whole-array erase typically 13 s; poll limit allows 2x that
  localparam int CHIP_ERASE_S    = 13;
  localparam longint TIMEOUT_CYC_L =
    longint'(CHIP_ERASE_S) * 2 * 64'h3B9ACA00 / CLK_NS;
  localparam int TIMEOUT_CYC     = int'(TIMEOUT_CYC_L);
endpackage
`default_nettype wire

// File: verilog/sync3.sv
`timescale 1ns/1ps
`default_nettype none
module sync3 #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg;
  logic [W-1:0] q_next;
  // ==========================================================
  // per bit: accept a change once stages two and three agree
  always_comb
  begin
    for (int i = 0; i < W; i++)
      q_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : q_reg[i];
  end
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg  <= '0;
    end
    else
    begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg  <= q_next;
    end
  end
  assign q = q_reg;
endmodule
`default_nettype wire

// File: verilog/flash_erase_host.sv
// Contract
// - chip erase ends with a write to word address 555
// - sector erase ends with a write to an address in the sector
// - chip erase final data byte is 10H
// - sector erase final data byte is 30H
// - output enable stays high throughout command writes
// - status is read by toggling output enable, once per read
// - polling reads keep one fixed address
// - done when two successive toggle bits are equal
`timescale 1ns/1ps
`default_nettype none
module flash_erase_host #(
  parameter int TIMEOUT = flash_erase_pkg::TIMEOUT_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire logic        chip_mode,
  input  wire logic [20:0] sector_addr,
  output logic             busy,
  output logic             done,
  output logic             timed_out,
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic [20:0]      addr,
  output logic [15:0]      dq_out,
  output logic             dq_oe_n,
  input  wire logic [15:0] dq_in
);
  typedef enum logic [2:0]
    {IDLE, WR_LOW, WR_HIGH, RD_LOW, RD_HIGH} state_t;
  state_t      state_reg, state_next;
  logic [2:0]  idx_reg, idx_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic [31:0] tmo_reg, tmo_next;
  logic        chip_reg, chip_next;
  logic [20:0] sect_reg, sect_next;
  logic        have_reg, have_next;
  logic        last_reg, last_next;
  logic        ce_n_reg, ce_n_next, oe_n_reg, oe_n_next;
  logic        we_n_reg, we_n_next, doe_reg, doe_next;
  logic [20:0] addr_reg, addr_next;
  logic [15:0] dout_reg, dout_next;
  logic        busy_reg, busy_next, done_reg, done_next;
  logic        tmo_flag_reg, tmo_flag_next;
  logic [15:0] dq_sync;
  logic [20:0] cmd_addr;
  logic [7:0]  cmd_data;
  logic        tbit;

  // ==========================================================
  // data bus input resynchroniser
  sync3 #(.W(16)) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     (dq_in),
    .q     (dq_sync)
  );
  assign tbit = dq_sync[flash_erase_pkg::TOGGLE_BIT];

  // ==========================================================
  // six-write erase command sequence table
  always_comb
  begin
    cmd_addr = flash_erase_pkg::UNLOCK_ADDR_1;
    cmd_data = flash_erase_pkg::UNLOCK_DATA_1;
    case (idx_reg)
      3'h1, 3'h4:
      begin
        cmd_addr = flash_erase_pkg::UNLOCK_ADDR_2;
        cmd_data = flash_erase_pkg::UNLOCK_DATA_2;
      end
      3'h2: cmd_data = flash_erase_pkg::ERASE_SETUP;
      3'h5:
      begin
        cmd_addr = chip_reg ? flash_erase_pkg::CHIP_ERASE_ADDR
                            : sect_reg;
        cmd_data = chip_reg ? flash_erase_pkg::CHIP_ERASE_CMD
                            : flash_erase_pkg::SECTOR_ERASE_CMD;
      end
      default: ;
    endcase
  end

  // ==========================================================
  // sequencer: writes, then toggle polling until stable
  always_comb
  begin
    state_next = state_reg;
    idx_next = idx_reg;
    cnt_next = cnt_reg;
    tmo_next = tmo_reg;
    chip_next = chip_reg;
    sect_next = sect_reg;
    have_next = have_reg;
    last_next = last_reg;
    ce_n_next = ce_n_reg;
    oe_n_next = oe_n_reg;
    we_n_next = we_n_reg;
    doe_next = doe_reg;
    addr_next = addr_reg;
    dout_next = dout_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    tmo_flag_next = tmo_flag_reg;
    if (cnt_reg != 4'h0)
      cnt_next = cnt_reg - 4'h1;
    case (state_reg)
      IDLE:
        if (start)
        begin
          chip_next = chip_mode;
          sect_next = sector_addr;
          idx_next = 3'h0;
          busy_next = 1'b1;
          tmo_flag_next = 1'b0;
          oe_n_next = 1'b1;
          state_next = WR_HIGH;
          cnt_next = 4'(flash_erase_pkg::WPH_CYC);
        end
      WR_HIGH:
        if (cnt_reg == 4'h0)
        begin
          if (idx_reg == 3'(flash_erase_pkg::WRITE_COUNT))
          begin
            doe_next = 1'b1;
            have_next = 1'b0;
            tmo_next = 32'(TIMEOUT);
            addr_next = sect_reg;
            state_next = RD_LOW;
            cnt_next = 4'(flash_erase_pkg::OE_CYC);
            ce_n_next = 1'b0;
            oe_n_next = 1'b0;
          end
          else
          begin
            addr_next = cmd_addr;
            dout_next = {8'h00, cmd_data};
            doe_next = 1'b0;
            ce_n_next = 1'b0;
            we_n_next = 1'b0;
            cnt_next = 4'(flash_erase_pkg::WP_CYC);
            state_next = WR_LOW;
          end
        end
      WR_LOW:
        if (cnt_reg == 4'h0)
        begin
          we_n_next = 1'b1;
          ce_n_next = 1'b1;
          idx_next = idx_reg + 3'h1;
          cnt_next = 4'(flash_erase_pkg::AH_CYC);
          state_next = WR_HIGH;
        end
      RD_LOW:
        if (cnt_reg == 4'h0)
        begin
          // one read access per low pulse of output enable
          oe_n_next = 1'b1;
          ce_n_next = 1'b1;
          have_next = 1'b1;
          last_next = tbit;
          cnt_next = 4'(flash_erase_pkg::OEHP_CYC);
          state_next = RD_HIGH;
          if (have_reg && tbit == last_reg)
          begin
            doe_next = 1'b1;
            busy_next = 1'b0;
            done_next = 1'b1;
            state_next = IDLE;
          end
          else if (tmo_reg == 32'h0)
          begin
            busy_next = 1'b0;
            done_next = 1'b1;
            tmo_flag_next = 1'b1;
            state_next = IDLE;
          end
        end
      RD_HIGH:
        if (cnt_reg == 4'h0)
        begin
          ce_n_next = 1'b0;
          oe_n_next = 1'b0;
          cnt_next = 4'(flash_erase_pkg::OE_CYC);
          state_next = RD_LOW;
        end
      default: state_next = IDLE;
    endcase
    if (state_reg == RD_LOW || state_reg == RD_HIGH)
      if (tmo_reg != 32'h0)
        tmo_next = tmo_reg - 32'h1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg <= IDLE;
      idx_reg <= 3'h0;
      cnt_reg <= 4'h0;
      tmo_reg <= 32'h0;
      chip_reg <= 1'b0;
      sect_reg <= 21'h000000;
      have_reg <= 1'b0;
      last_reg <= 1'b0;
      ce_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      doe_reg <= 1'b1;
      addr_reg <= 21'h000000;
      dout_reg <= 16'h0000;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      tmo_flag_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      cnt_reg <= cnt_next;
      tmo_reg <= tmo_next;
      chip_reg <= chip_next;
      sect_reg <= sect_next;
      have_reg <= have_next;
      last_reg <= last_next;
      ce_n_reg <= ce_n_next;
      oe_n_reg <= oe_n_next;
      we_n_reg <= we_n_next;
      doe_reg <= doe_next;
      addr_reg <= addr_next;
      dout_reg <= dout_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      tmo_flag_reg <= tmo_flag_next;
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;
  assign timed_out = tmo_flag_reg;
  assign ce_n = ce_n_reg;
  assign oe_n = oe_n_reg;
  assign we_n = we_n_reg;
  assign addr = addr_reg;
  assign dq_out = dout_reg;
  assign dq_oe_n = doe_reg;

  // ==========================================================
  // checks
  oe_write_a: assert property (@(posedge clk) disable iff (reset)
    !we_n_reg |-> oe_n_reg && !ce_n_reg && !doe_reg)
    else $error("output enable low during write");
  chip_final_a: assert property (@(posedge clk)
    disable iff (reset)
    ($fell(we_n_reg) && idx_reg == 3'h5 && chip_reg) |->
    addr_reg == 21'h000555 && dout_reg[7:0] == 8'h10)
    else $error("bad chip erase final write");
  sect_final_a: assert property (@(posedge clk)
    disable iff (reset)
    ($fell(we_n_reg) && idx_reg == 3'h5 && !chip_reg) |->
    addr_reg == sect_reg && dout_reg[7:0] == 8'h30)
    else $error("bad sector erase final write");
  // every polling cycle must sit on the one address latched at start
  poll_addr_a: assert property (@(posedge clk) disable iff (reset)
    (state_reg == RD_LOW || state_reg == RD_HIGH) |->
    addr_reg == sect_reg)
    else $error("polling address moved");
  read_pulse_a: assert property (@(posedge clk) disable iff (reset)
    $fell(oe_n_reg) && state_reg == RD_LOW |->
    !oe_n_reg [*4])
    else $error("read pulse too short");
  done_equal_a: assert property (@(posedge clk)
    disable iff (reset)
    $rose(done_reg) && !tmo_flag_reg |->
    $past(tbit) == $past(last_reg))
    else $error("done without equal reads");
  tmo_end_a: assert property (@(posedge clk)
    disable iff (reset)
    (state_reg == RD_LOW && tmo_reg == 32'h0 && cnt_reg == 4'h0) |=>
    state_reg == IDLE && !busy_reg)
    else $error("timeout not honoured");
  busy_done_a: assert property (@(posedge clk) disable iff (reset)
    done_reg |-> !busy_reg && $past(busy_reg))
    else $error("done without busy");
  chip_cov: cover property (@(posedge clk) disable iff (reset)
    done_reg && chip_reg && !tmo_flag_reg);
  sect_cov: cover property (@(posedge clk) disable iff (reset)
    done_reg && !chip_reg && !tmo_flag_reg);
  tmo_cov: cover property (@(posedge clk) disable iff (reset)
    done_reg && tmo_flag_reg);
endmodule
`default_nettype wire

// File: test/flash_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// behavioural flash device, clockless, erase and toggle only
module flash_dev_model #(
  parameter int SMALL_NS = 3000,
  parameter int LARGE_NS = 6000,
  parameter int CHIP_NS  = 9000
) (
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [20:0] addr,
  input  wire logic [15:0] dq_out,
  input  wire logic        dq_oe_n,
  output logic      [15:0] dq_in
);
  logic [20:0] wa [8];
  logic [7:0]  wd [8];
  int          nw = 0;
  int          reads = 0;
  int          chip_ns = CHIP_NS;
  realtime     done_t = 0;
  logic        tog = 1'b0;
  logic        bad = 1'b0;
  logic [20:0] pa = 21'h000000;
  logic [15:0] last = 16'h0000;
  logic        wr_n;
  logic        wr_low = 1'b0;

  // both strobes rise on one edge, so the write ends on the first riser
  assign wr_n = we_n | ce_n;
  always @(negedge wr_n) wr_low = 1'b1;

  // latch each write as the first of the two strobes rises
  always @(posedge wr_n)
  begin
    if (wr_low)
    begin
      wr_low = 1'b0;
      if (oe_n !== 1'b1 || dq_oe_n !== 1'b0) bad = 1'b1;
      if (nw < 8)
      begin
        wa[nw] = addr;
        wd[nw] = dq_out[7:0];
      end
      nw = nw + 1;
      if (dq_out[7:0] == 8'h30)
        done_t = $realtime + ((addr[20:15] == 6'h3F) ?
                 SMALL_NS : LARGE_NS);
      if (dq_out[7:0] == 8'h10 && addr == 21'h000555)
        done_t = $realtime + chip_ns;
    end
  end

  // each read access flips the status bit only while erasing
  always @(negedge oe_n or negedge ce_n)
  begin
    // let the host's same-edge bus release settle before judging it
    #1;
    if (!oe_n && !ce_n)
    begin
      if (dq_oe_n !== 1'b1) bad = 1'b1;
      reads = reads + 1;
      if (reads == 1) pa = addr;
      else if (addr !== pa) bad = 1'b1;
      if ($realtime < done_t) tog = ~tog;
    end
  end

  // released bus shows the inverse, not a stale copy
  always @(posedge oe_n) last = {9'h000, tog, 6'h00};
  assign dq_in = (!ce_n && !oe_n) ? {9'h000, tog, 6'h00} : ~last;
endmodule
`default_nettype wire

// File: test/flash_erase_host_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// erase host bench
module flash_erase_host_bench;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        start = 1'b0;
  logic        chip_mode = 1'b0;
  logic [20:0] sector_addr = 21'h000000;
  logic        busy;
  logic        done;
  logic        timed_out;
  logic        ce_n;
  logic        oe_n;
  logic        we_n;
  logic [20:0] addr;
  logic [15:0] dq_out;
  logic        dq_oe_n;
  logic [15:0] dq_in;
  int          mismatches = 0;
  int          compares = 0;
  int          cyc = 0;

  always #20 clk = ~clk;

  flash_erase_host #(.TIMEOUT(2000)) dut (
    .clk(clk), .reset(reset), .start(start), .chip_mode(chip_mode),
    .sector_addr(sector_addr), .busy(busy), .done(done),
    .timed_out(timed_out), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .addr(addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));

  flash_dev_model dev (
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));

  // ==========================================================
  // reporting
  task automatic chk(input bit ok, input string msg);
    compares++;
    if (!ok)
    begin
      mismatches++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // hang guard: the whole run needs about 3000 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      final_report;
    end
  end

  // ==========================================================
  // one erase, with a refused second start while busy
  task automatic run_erase(input logic cm, input logic [20:0] sa,
                           input bit to, input string name);
    logic [20:0] ea [6];
    logic [7:0]  ed [6];
    int          n;
    ea = '{21'h000555, 21'h0002AA, 21'h000555, 21'h000555,
           21'h0002AA, cm ? 21'h000555 : sa};
    ed = '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55, cm ? 8'h10 : 8'h30};
    dev.nw = 0;
    dev.reads = 0;
    dev.bad = 1'b0;
    @(posedge clk);
    #2;
    start = 1'b1;
    chip_mode = cm;
    sector_addr = sa;
    @(posedge clk);
    #2;
    chip_mode = ~cm;
    sector_addr = 21'h0F0F0F;
    chk(busy === 1'b1, "busy after start");
    @(posedge clk);
    #2;
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 4000)
    begin
      @(posedge clk);
      #2;
      n++;
    end
    chk(done === 1'b1, "no done");
    chk(busy === 1'b0, "busy after done");
    chk(timed_out === to, "timeout flag");
    chk(dev.nw == 6, "write count");
    for (int i = 0; i < 6; i++)
    begin
      chk(dev.wa[i] === ea[i], "write address");
      chk(dev.wd[i] === ed[i], "write data");
    end
    chk(($realtime >= dev.done_t) == !to, "done vs erase");
    chk(dev.reads >= 2, "poll reads");
    chk(dev.bad === 1'b0, "strobe or address");
    $display("test %s finished", name);
  endtask

  // ==========================================================
  // reset in mid-poll must drop every strobe back to idle
  task automatic reset_mid;
    @(posedge clk);
    #2;
    start = 1'b1;
    chip_mode = 1'b1;
    @(posedge clk);
    #2;
    start = 1'b0;
    repeat (60) @(posedge clk);
    #2;
    chk(busy === 1'b1, "busy before reset");
    reset = 1'b1;
    @(posedge clk);
    #2;
    chk(busy === 1'b0 && done === 1'b0, "status after reset");
    chk({ce_n, oe_n, we_n, dq_oe_n} === 4'hF, "strobes after reset");
    reset = 1'b0;
    $display("test mid reset finished");
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    #2;
    reset = 1'b0;
    run_erase(1'b0, 21'h1FA123, 1'b0, "small sector");
    run_erase(1'b0, 21'h012345, 1'b0, "large sector");
    run_erase(1'b1, 21'h1FFFFF, 1'b0, "chip");
    dev.chip_ns = 1000000;
    reset_mid;
    run_erase(1'b1, 21'h000000, 1'b1, "chip timeout");
    dev.chip_ns = 9000;
    run_erase(1'b0, 21'h1F8000, 1'b0, "after timeout");
    final_report;
  end
endmodule
`default_nettype wire
